// ---- byte_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two; ready and valid come from registers
`timescale 1ns/10ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,        // clock
  input  wire logic             rst_n,      // async reset, active low
  input  wire logic             in_valid,   // write request
  output logic                  in_ready,   // room available
  input  wire logic [WIDTH-1:0] in_data,    // write data
  output logic                  out_valid,  // data available
  input  wire logic             out_ready,  // consumer takes word
  output logic      [WIDTH-1:0] out_data    // head word
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q, rd_ptr_q;
  logic [AW:0]      cnt_q, cnt_d;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // count change; ready/valid registered from the next count
  assign cnt_d    = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != FULL_CNT);
      out_valid <= (cnt_d != '0);
    end
  end

  // storage needs no reset
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_ptr_q] <= in_data;
  end
endmodule // byte_fifo

// ---- dma_partner.sv ----
// far-side model: dma controller acknowledges and the external shifter
// assumes the block's clock; the block synchronises the acks itself
`timescale 1ns/10ps
module dma_partner #(
  parameter int CHAR_CYC = 20
) (
  input  wire logic       clk,               // clock
  input  wire logic       rst_n,             // async reset, active low
  input  wire logic [1:0] ack_en,            // per channel: controller willing
  input  wire logic       ack_slow,          // long ack latency
  input  wire logic       rx_dma_burst_req,  // rx burst request
  input  wire logic       rx_dma_single_req, // rx single request
  input  wire logic       tx_dma_burst_req,  // tx burst request
  input  wire logic       tx_dma_single_req, // tx single request
  output logic            dma_ack_rx,        // rx acknowledge
  output logic            dma_ack_tx,        // tx acknowledge
  input  wire logic       tx_start,          // start pulse
  input  wire logic [7:0] tx_char,           // character
  output logic            tx_busy            // shifter busy
);
  logic [7:0]  sent [$];
  logic [1:0]  req;
  logic [1:0]  ack;
  logic [3:0]  wait_q [2];
  int unsigned bit_cnt;

  // every request is taken as lying in the single region
  assign req = {tx_dma_burst_req | tx_dma_single_req, rx_dma_burst_req | rx_dma_single_req};
  // one ack per request, never more than a threshold's worth of data
  assign dma_ack_rx = ack[0];
  assign dma_ack_tx = ack[1];

  // four-phase loop: ack after a wait, released only once request is gone
  always @(posedge clk or negedge rst_n) begin
    for (int i = 0; i < 2; i++) begin
      if (!rst_n) begin
        ack[i]    <= 1'b0;
        wait_q[i] <= 4'h0;
      end else if (!ack[i] && req[i] && ack_en[i]) begin
        if (wait_q[i] == 4'h0) ack[i] <= 1'b1;
        wait_q[i] <= wait_q[i] - 4'h1;
      end else if (!ack[i]) begin
        wait_q[i] <= ack_slow ? 4'h9 : 4'h1;
      end else if (!req[i]) begin
        ack[i] <= 1'b0;
      end
    end
  end

  // shifter: busy from the cycle after start, for CHAR_CYC cycles
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      bit_cnt <= 0;
    end else if (tx_start) begin
      tx_busy <= 1'b1;
      bit_cnt <= CHAR_CYC;
      sent.push_back(tx_char);
    end else if (bit_cnt != 0) begin
      bit_cnt <= bit_cnt - 1;
      tx_busy <= (bit_cnt != 1);
    end
  end
endmodule // dma_partner

// ---- sync2.sv ----
// two-flop level synchroniser, one per bit
// assumes inputs are levels that hold for at least two clocks
`timescale 1ns/10ps
module sync2 #(
  parameter int unsigned WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,      // clock
  input  wire logic             rst_n,    // async reset, active low
  input  wire logic [WIDTH-1:0] d,        // asynchronous levels
  output logic      [WIDTH-1:0] q         // synchronised levels
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // sync2

// ---- tb.sv ----
// testbench for the dma handshake, flow control and auto-baud block
// assumes dma_partner stands in for the controller and the shifter
`timescale 1ns/10ps
module tb;
  import uart_flow_pkg::*;
  localparam int CHAR = 20;
  logic        clk, rst_n, fifo_mode_enable, tx_trig_sel, dma_ack_rx, dma_ack_tx;
  logic [1:0]  rx_trig_sel, ack_en;
  logic [6:0]  rx_level, tx_level;
  logic        rx_dma_burst_req, rx_dma_single_req, tx_dma_burst_req, tx_dma_single_req;
  logic        auto_flow_enable, rts_control, infrared_mode, clear_to_send_in_n;
  logic        request_to_send_out_n, txq_valid, txq_ready, tx_busy, tx_start, ack_slow;
  logic [7:0]  txq_data, tx_char;
  logic        rxd, autobaud_enable_set, autobaud_auto_update, autobaud_lock_ie;
  logic        divisor_wr, autobaud_enable, autobaud_lock_irq;
  logic [15:0] divisor_wdata, autobaud_count, divisor;
  logic [6:0]  wm [4] = '{7'h01, 7'h08, 7'h10, 7'h20};
  logic [6:0]  tt [2] = '{7'h20, 7'h40};
  int          num_errors, cmp_count, cyc, locks, n;

  uart_flow_dma dut (.clk, .rst_n, .fifo_mode_enable, .tx_trig_sel, .rx_trig_sel,
    .rx_level, .tx_level, .dma_ack_rx, .dma_ack_tx, .rx_dma_burst_req, .rx_dma_single_req,
    .tx_dma_burst_req, .tx_dma_single_req, .auto_flow_enable, .rts_control, .infrared_mode,
    .clear_to_send_in_n, .request_to_send_out_n, .txq_valid, .txq_ready, .txq_data,
    .tx_busy, .tx_start, .tx_char, .rxd, .autobaud_enable_set, .autobaud_auto_update,
    .autobaud_lock_ie, .divisor_wr, .divisor_wdata, .autobaud_enable, .autobaud_count,
    .autobaud_lock_irq, .divisor);
  dma_partner #(.CHAR_CYC(CHAR)) far (.clk, .rst_n, .ack_en, .ack_slow, .rx_dma_burst_req,
    .rx_dma_single_req, .tx_dma_burst_req, .tx_dma_single_req, .dma_ack_rx, .dma_ack_tx,
    .tx_start, .tx_char, .tx_busy);

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // lock pulses and a runaway guard well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (autobaud_lock_irq === 1'b1) locks <= locks + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  function automatic logic [1:0] reqs(input bit ch);
    return ch ? {tx_dma_burst_req, tx_dma_single_req} : {rx_dma_burst_req, rx_dma_single_req};
  endfunction

  task automatic set_lvl(input bit ch, input logic [6:0] v);
    if (ch) tx_level = v;
    else rx_level = v;
    tick(5);
  endtask

  // drop the condition first, so whatever stays up is held by the handshake alone
  task automatic drain(input bit ch, input logic [1:0] held);
    int k;
    k = 0;
    set_lvl(ch, ch ? 7'h40 : 7'h00);
    chk(reqs(ch), held, "req held");
    ack_en[ch] = 1'b1;
    while (!(ch ? dma_ack_tx : dma_ack_rx) && k < 40) begin
      tick(1);
      k++;
    end
    tick(2);
    chk(reqs(ch), held, "req before sync");
    tick(1);
    chk(reqs(ch), 2'b00, "req after ack");
    ack_en[ch] = 1'b0;
    tick(8);
  endtask

  task automatic wait_sent(input int k);
    int m;
    m = 0;
    while (far.sent.size() < k && m < 200) begin
      tick(1);
      m++;
    end
  endtask

  initial begin
    {fifo_mode_enable, tx_trig_sel, rx_trig_sel, ack_en, ack_slow} = '0;
    {auto_flow_enable, rts_control, infrared_mode, txq_valid, txq_data} = '0;
    {autobaud_enable_set, autobaud_auto_update, autobaud_lock_ie, divisor_wr} = '0;
    {divisor_wdata, num_errors, cmp_count, cyc, locks} = '0;
    {rxd, clear_to_send_in_n, rst_n, rx_level, tx_level} = {2'b11, 1'b0, 7'h00, 7'h40};
    tick(6);
    chk({rx_dma_burst_req, rx_dma_single_req, tx_dma_burst_req, tx_dma_single_req}, 0, "rst req");
    chk({request_to_send_out_n, txq_ready, tx_start, autobaud_enable}, 4'h4, "rst flags");
    chk(divisor, 16'h0001, "rst divisor");
    chk(autobaud_count, 16'h0000, "rst count");
    rst_n = 1'b1;
    tick(4);
    // rx channel at each watermark and just under it, prompt and slow acks
    fifo_mode_enable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rx_trig_sel = 2'(i);
      ack_slow = i[0];
      set_lvl(0, wm[i]);
      chk(reqs(0), 2'b11, "rx at mark");
      drain(0, 2'b11);
      set_lvl(0, wm[i] - 7'h01);
      chk(reqs(0), {1'b0, i != 0}, "rx under mark");
      if (i != 0) drain(0, 2'b01);
    end
    // tx channel at both empty-space thresholds
    for (int i = 0; i < 2; i++) begin
      tx_trig_sel = i[0];
      set_lvl(1, 7'h40);
      chk(reqs(1), 2'b00, "tx full");
      set_lvl(1, 7'h40 - tt[i]);
      chk(reqs(1), 2'b11, "tx at mark");
      drain(1, 2'b11);
      set_lvl(1, 7'h41 - tt[i]);
      chk(reqs(1), 2'b01, "tx under mark");
      drain(1, 2'b01);
    end
    fifo_mode_enable = 1'b0;
    set_lvl(0, 7'h40);
    chk(reqs(0), 2'b01, "rx no fifo");
    drain(0, 2'b01);
    set_lvl(1, 7'h00);
    chk(reqs(1), 2'b01, "tx no fifo");
    drain(1, 2'b01);
    $display("test dma finished, errors %0d", num_errors);
    // flow enables off, cts only, both: rts follows the mark only in the last
    rx_trig_sel = 2'b10;
    for (int i = 0; i < 3; i++) begin
      {auto_flow_enable, rts_control} = (i == 0) ? 2'b01 : ((i == 1) ? 2'b10 : 2'b11);
      set_lvl(0, 7'h10);
      chk(request_to_send_out_n, i == 2, "rts at mark");
      set_lvl(0, 7'h0F);
      chk(request_to_send_out_n, 1'b0, "rts drained");
    end
    drain(0, 2'b01);
    $display("test flow finished, errors %0d", num_errors);
    // cts only with the pin high: queue fills and nothing may start
    {auto_flow_enable, rts_control} = 2'b10;
    n = 0;
    while (txq_ready === 1'b1 && n < 8) begin
      txq_valid = 1'b1;
      txq_data = 8'hA0 + 8'(n);
      tick(1);
      n++;
    end
    txq_valid = 1'b0;
    tick(20);
    chk(16'(n), 16'h0004, "queue depth");
    chk(16'(far.sent.size()), 16'h0000, "held by cts");
    clear_to_send_in_n = 1'b0;
    wait_sent(1);
    clear_to_send_in_n = 1'b1;
    tick(3 * CHAR);
    chk(16'(far.sent.size()), 16'h0001, "stop after char");
    {auto_flow_enable, rts_control, infrared_mode, clear_to_send_in_n} = 4'hE;
    tick(3 * CHAR);
    chk(16'(far.sent.size()), 16'h0001, "infrared blocks");
    infrared_mode = 1'b0;
    wait_sent(4);
    for (int i = 0; i < 4; i++) chk(far.sent[i], 16'h00A0 + 16'(i), "sent order");
    // cts control off: the pin is ignored
    {auto_flow_enable, clear_to_send_in_n, txq_valid, txq_data} = {3'b011, 8'hB0};
    tick(1);
    txq_valid = 1'b0;
    wait_sent(5);
    chk(far.sent[4], 16'h00B0, "cts ignored");
    chk(txq_ready, 1'b1, "queue empty");
    $display("test tx finished, errors %0d", num_errors);
    // auto-baud: first run loads divisor and locks, second only measures
    {autobaud_auto_update, autobaud_lock_ie} = 2'b11;
    for (int i = 0; i < 2; i++) begin
      autobaud_enable_set = 1'b1;
      tick(1);
      autobaud_enable_set = 1'b0;
      tick(4);
      chk(autobaud_enable, 1'b1, "ab running");
      rxd = 1'b0;
      tick(i ? 96 : 160);
      rxd = 1'b1;
      tick(6);
      chk(autobaud_count, i ? 16'h0060 : 16'h00A0, "ab count");
      chk(autobaud_enable, 1'b0, "ab self clear");
      chk(16'(locks), 16'h0001, "lock pulse");
      chk(divisor, 16'h000A, "divisor load");
      {autobaud_auto_update, autobaud_lock_ie} = 2'b00;
    end
    rxd = 1'b0;
    tick(30);
    rxd = 1'b1;
    tick(6);
    chk(autobaud_count, 16'h0060, "no rerun");
    {divisor_wr, divisor_wdata} = {1'b1, 16'h1234};
    tick(1);
    divisor_wr = 1'b0;
    tick(2);
    chk(divisor, 16'h1234, "sw divisor");
    $display("test autobaud finished, errors %0d", num_errors);
    give_verdict();
  end
endmodule // tb

// ---- uart_flow_dma.sv ----
// dma request handshake, rts/cts hardware flow control and auto-baud detect
// assumes fifo levels come from the fifo logic in this clock; dma side async
// Function
// [R1] separate burst and single requests, may overlap
// [R2] rx above watermark raises burst and single
// [R3] rx below watermark raises single only
// [R4] fifo mode off: single requests only
// [R5] tx trigger bit selects 32 or 64
// [R6] rx trigger field selects 1, 8, 16, 32
// [R7] controller burst size not above threshold
// [R8] burst request held until acknowledge arrives
// [R9] request dropped as soon as acknowledge seen
// [R10] single transfer uses four-phase handshake
// [R11] controller samples single only in region
// [R12] flow enable bits decode off, cts, both
// [R13] rts_n deasserts when rx reaches watermark
// [R14] rts_n reasserts once rx drains below watermark
// [R15] remote stops after current character
// [R16] cts checked before each byte sent
// [R17] cts loss finishes current character then stops
// [R18] infrared with full auto-flow blocks transmitter
// [R19] start bit measured into auto-baud count
// [R20] auto-update loads divisor from measured count
// [R21] detection clears its own enable
// [R22] software avoids baud change while busy
// [R23] dma handshake signals synchronised at boundary
`timescale 1ns/10ps
module uart_flow_dma
  import uart_flow_pkg::*;
#(
  parameter int unsigned TXQ_DEPTH = 4,
  parameter int unsigned DATA_W    = 8
) (
  input  wire logic                      clk,                   // peripheral clock
  input  wire logic                      rst_n,                 // async reset
  input  wire logic                      fifo_mode_enable,      // fifo mode on
  input  wire logic                      tx_trig_sel,           // tx dma trigger select
  input  wire logic [1:0]                rx_trig_sel,           // rx dma trigger select
  input  wire logic [uart_flow_pkg::LVL_W-1:0] rx_level,        // entries in rx fifo
  input  wire logic [uart_flow_pkg::LVL_W-1:0] tx_level,        // entries in tx fifo
  input  wire logic                      dma_ack_rx,            // rx channel acknowledge
  input  wire logic                      dma_ack_tx,            // tx channel acknowledge
  output logic                           rx_dma_burst_req,      // rx burst request
  output logic                           rx_dma_single_req,     // rx single request
  output logic                           tx_dma_burst_req,      // tx burst request
  output logic                           tx_dma_single_req,     // tx single request
  input  wire logic                      auto_flow_enable,      // modem control auto-flow
  input  wire logic                      rts_control,           // modem control rts bit
  input  wire logic                      infrared_mode,         // infrared mode selected
  input  wire logic                      clear_to_send_in_n,    // cts pin, active low
  output logic                           request_to_send_out_n, // rts pin, active low
  input  wire logic                      txq_valid,             // character offered
  output logic                           txq_ready,             // room in holding queue
  input  wire logic [DATA_W-1:0]         txq_data,              // character
  input  wire logic                      tx_busy,               // shifter sending a char
  output logic                           tx_start,              // pulse: send tx_char
  output logic [DATA_W-1:0]              tx_char,               // character to send
  input  wire logic                      rxd,                   // serial receive pin
  input  wire logic                      autobaud_enable_set,   // pulse: start detection
  input  wire logic                      autobaud_auto_update,  // load divisor itself
  input  wire logic                      autobaud_lock_ie,      // lock interrupt enable
  input  wire logic                      divisor_wr,            // software divisor write
  input  wire logic [uart_flow_pkg::ABC_W-1:0] divisor_wdata,   // software divisor
  output logic                           autobaud_enable,       // detection running
  output logic [uart_flow_pkg::ABC_W-1:0] autobaud_count,       // measured cycles
  output logic                           autobaud_lock_irq,     // pulse: baud locked
  output logic [uart_flow_pkg::ABC_W-1:0] divisor               // divisor latch
);
  import uart_flow_pkg::*;

  // threshold decode; the rx one is shared by dma and rts logic
  function automatic logic [LVL_W-1:0] rx_wm(input logic [1:0] sel);
    unique case (sel)
      2'h0: rx_wm = RX_TRIG_0;
      2'h1: rx_wm = RX_TRIG_1;
      2'h2: rx_wm = RX_TRIG_2;
      2'h3: rx_wm = RX_TRIG_3;
    endcase
  endfunction

  function automatic logic [LVL_W-1:0] tx_wm(input logic sel);
    tx_wm = sel ? TX_TRIG_HI : TX_TRIG_LO;
  endfunction

  // crossing: acks come from the controller domain, pins are asynchronous
  logic [3:0] sync_q;
  sync2 #(.WIDTH(4), .RST_VAL(SYNC_RESET)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({rxd, clear_to_send_in_n, dma_ack_tx, dma_ack_rx}),
    .q     (sync_q)
  ); // R23

  wire       ack_rx_s = sync_q[0];
  wire       ack_tx_s = sync_q[1];
  wire       cts_n_s  = sync_q[2];
  wire       rxd_s    = sync_q[3];
  wire [1:0] ack_s    = {ack_tx_s, ack_rx_s};

  // watermark levels and request conditions
  wire [LVL_W-1:0] rx_wm_lvl = rx_wm(rx_trig_sel);                 // R6
  wire [LVL_W-1:0] tx_wm_lvl = tx_wm(tx_trig_sel);                 // R5
  wire [LVL_W-1:0] tx_empty  = LVL_FULL - tx_level;
  wire             rx_at_wm  = (rx_level >= rx_wm_lvl);
  wire [1:0]       burst_cond;
  wire [1:0]       single_cond;
  // burst only in fifo mode; single whenever anything can move
  assign burst_cond[CH_RX]  = fifo_mode_enable & rx_at_wm;          // R2 R4
  assign single_cond[CH_RX] = (rx_level != '0);                     // R3
  assign burst_cond[CH_TX]  = fifo_mode_enable & (tx_empty >= tx_wm_lvl); // R4
  assign single_cond[CH_TX] = fifo_mode_enable ? (tx_empty != '0)
                                               : (tx_level == '0);

  // per-channel request handshake
  logic [1:0] burst_q, single_q;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_dma
      dma_state_e st_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          st_q         <= DMA_IDLE;
          burst_q[ch]  <= 1'b0;
          single_q[ch] <= 1'b0;
        end else begin
          unique case (st_q)
            DMA_IDLE: begin
              if (!ack_s[ch] && burst_cond[ch]) begin
                burst_q[ch]  <= 1'b1;                               // R1
                single_q[ch] <= single_cond[ch];                    // R2
                st_q         <= DMA_BURST;
              end else if (!ack_s[ch] && single_cond[ch]) begin
                single_q[ch] <= 1'b1;                               // R3 R10
                st_q         <= DMA_SINGLE;
              end
            end
            // held regardless of the condition until acknowledge
            DMA_BURST, DMA_SINGLE: begin
              if (ack_s[ch]) begin
                burst_q[ch]  <= 1'b0;                               // R9
                single_q[ch] <= 1'b0;                               // R10
                st_q         <= DMA_DONE;
              end                                                   // R8
            end
            // wait for the controller to close the loop
            DMA_DONE: begin
              if (!ack_s[ch]) st_q <= DMA_IDLE;                     // R10
            end
          endcase
        end
      end
    end
  endgenerate

  assign rx_dma_burst_req  = burst_q[CH_RX];
  assign rx_dma_single_req = single_q[CH_RX];
  assign tx_dma_burst_req  = burst_q[CH_TX];
  assign tx_dma_single_req = single_q[CH_TX];

  // flow-control decode
  wire cts_en   = auto_flow_enable;                                 // R12
  wire rts_en   = auto_flow_enable & rts_control;                   // R12
  wire tx_block = infrared_mode & rts_en;                           // R18
  wire cts_ok   = !cts_en || !cts_n_s;                              // R16

  // rts: held asserted (low) when not automated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) request_to_send_out_n <= 1'b0;
    else        request_to_send_out_n <= rts_en & rx_at_wm;         // R13 R14
  end

  // transmit holding queue; stalls the source when full
  logic              q_valid;
  logic [DATA_W-1:0] q_data;
  wire               q_pop;
  byte_fifo #(.WIDTH(DATA_W), .DEPTH(TXQ_DEPTH)) u_txq (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (txq_valid),
    .in_ready  (txq_ready),
    .in_data   (txq_data),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data)
  );

  // a byte starts only between characters, so cts loss ends after the current one
  assign q_pop = q_valid & !tx_busy & !tx_start & cts_ok & !tx_block; // R16 R17 R18

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_start <= 1'b0;
      tx_char  <= '0;
    end else begin
      tx_start <= q_pop;
      if (q_pop) tx_char <= q_data;
    end
  end

  // auto-baud: wait for idle line, then time the low start bit
  ab_state_e        ab_q;
  logic [ABC_W-1:0] ab_cnt_q;
  logic             rxd_prev_q;
  wire              rxd_fall  = rxd_prev_q & !rxd_s;
  wire              rxd_rise  = !rxd_prev_q & rxd_s;
  wire              ab_done   = (ab_q == AB_MEASURE) && rxd_rise;
  wire [ABC_W-1:0]  ab_div    = ab_cnt_q >> OVERSAMPLE_SHIFT;
  // a divisor of zero would stall the baud generator
  wire [ABC_W-1:0]  ab_div_ok = (ab_div == '0) ? DIV_RESET : ab_div;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_q       <= AB_OFF;
      ab_cnt_q   <= '0;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_prev_q <= rxd_s;
      unique case (ab_q)
        AB_OFF:        if (autobaud_enable_set) ab_q <= AB_WAIT_IDLE;
        AB_WAIT_IDLE:  if (rxd_s) ab_q <= AB_WAIT_START;
        AB_WAIT_START: begin
          // the fall cycle is already the first low cycle of the start bit
          ab_cnt_q <= {{(ABC_W-1){1'b0}}, rxd_fall};                  // R19
          if (rxd_fall) ab_q <= AB_MEASURE;
        end
        AB_MEASURE: begin
          if (ab_cnt_q != ABC_MAX) ab_cnt_q <= ab_cnt_q + 1'b1;     // R19
          // a new set request in the lock cycle keeps detection alive
          if (rxd_rise) ab_q <= autobaud_enable_set ? AB_WAIT_IDLE : AB_OFF; // R21
        end
      endcase
    end
  end

  // results: count, lock pulse, divisor latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      autobaud_enable   <= 1'b0;
      autobaud_count    <= '0;
      autobaud_lock_irq <= 1'b0;
      divisor           <= DIV_RESET;
    end else begin
      autobaud_enable   <= (ab_q != AB_OFF) ? !(ab_done && !autobaud_enable_set)
                                            : autobaud_enable_set;
      autobaud_lock_irq <= ab_done & autobaud_lock_ie;              // R19
      if (ab_done) autobaud_count <= ab_cnt_q;                      // R19
      if (ab_done && autobaud_auto_update) divisor <= ab_div_ok;    // R20
      else if (divisor_wr) divisor <= divisor_wdata;
    end
  end

  // checks on the handshake, rts, cts and auto-baud
  sequence s_single_up;
    !ack_rx_s && !rx_dma_burst_req ##1 rx_dma_single_req && !rx_dma_burst_req;
  endsequence
  sequence s_single_close;
    ack_rx_s && rx_dma_single_req ##1 !rx_dma_single_req;
  endsequence

  property p_burst_hold;
    @(posedge clk) disable iff (!rst_n)
      tx_dma_burst_req && !ack_tx_s |=> tx_dma_burst_req;
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst dropped early"); // R8

  property p_drop_on_ack;
    @(posedge clk) disable iff (!rst_n)
      ack_rx_s && (rx_dma_burst_req || rx_dma_single_req)
        |=> !rx_dma_burst_req && !rx_dma_single_req;
  endproperty
  a_drop_on_ack: assert property (p_drop_on_ack) else $error("request kept after ack"); // R9

  property p_single_loop;
    @(posedge clk) disable iff (!rst_n)
      s_single_up ##[1:300] s_single_close |=> !rx_dma_single_req [*2];
  endproperty
  a_single_loop: assert property (p_single_loop) else $error("single loop broken"); // R10

  property p_no_burst_nofifo;
    @(posedge clk) disable iff (!rst_n)
      $rose(rx_dma_burst_req) || $rose(tx_dma_burst_req) |-> $past(fifo_mode_enable);
  endproperty
  a_no_burst_nofifo: assert property (p_no_burst_nofifo) else $error("burst without fifo"); // R4

  property p_both_req;
    @(posedge clk) disable iff (!rst_n)
      g_dma[0].st_q == DMA_IDLE && !ack_rx_s && fifo_mode_enable && rx_at_wm
        |=> rx_dma_burst_req && rx_dma_single_req;
  endproperty
  a_both_req: assert property (p_both_req) else $error("rx burst pair missing"); // R2

  property p_rts;
    @(posedge clk) disable iff (!rst_n)
      ##1 request_to_send_out_n == $past(rts_en && rx_level >= rx_wm_lvl);
  endproperty
  a_rts: assert property (p_rts) else $error("rts level wrong"); // R13

  property p_cts;
    @(posedge clk) disable iff (!rst_n)
      tx_start |-> $past(cts_ok) && !$past(tx_busy) && !$past(tx_block);
  endproperty
  a_cts: assert property (p_cts) else $error("byte sent without clearance"); // R16

  property p_ab_lock;
    @(posedge clk) disable iff (!rst_n)
      ab_done && !autobaud_enable_set
        |=> autobaud_count == $past(ab_cnt_q) && !autobaud_enable ##1 !autobaud_enable;
  endproperty
  a_ab_lock: assert property (p_ab_lock) else $error("auto-baud result wrong"); // R21

  property p_ab_update;
    @(posedge clk) disable iff (!rst_n)
      ab_done && autobaud_auto_update |=> divisor == $past(ab_div_ok);
  endproperty
  a_ab_update: assert property (p_ab_update) else $error("divisor not loaded"); // R20

endmodule // uart_flow_dma

// ---- uart_flow_pkg.sv ----
// package for the dma handshake, flow control and auto-baud block
// assumes a 64-entry fifo on each side whose fill level is supplied from outside
package uart_flow_pkg;

  // fifo geometry
  localparam int unsigned FIFO_DEPTH  = 64;
  localparam int unsigned LVL_W       = 7;
  localparam logic [6:0]  LVL_FULL    = 7'h40;

  // transmit trigger: number of empty locations
  localparam logic [6:0]  TX_TRIG_LO  = 7'h20;
  localparam logic [6:0]  TX_TRIG_HI  = 7'h40;

  // receive trigger: number of stored entries
  localparam logic [6:0]  RX_TRIG_0   = 7'h01;
  localparam logic [6:0]  RX_TRIG_1   = 7'h08;
  localparam logic [6:0]  RX_TRIG_2   = 7'h10;
  localparam logic [6:0]  RX_TRIG_3   = 7'h20;

  // auto-baud counter and divisor
  localparam int unsigned ABC_W       = 16;
  localparam int unsigned OVERSAMPLE_SHIFT = 4;
  localparam logic [15:0] ABC_MAX     = 16'hFFFF;
  localparam logic [15:0] DIV_RESET   = 16'h0001;

  // synchroniser reset levels: rxd, cts_n idle high, acks low
  localparam logic [3:0]  SYNC_RESET  = 4'hC;

  // dma channel index
  localparam int unsigned CH_RX       = 0;
  localparam int unsigned CH_TX       = 1;

  typedef enum logic [1:0] {DMA_IDLE, DMA_BURST, DMA_SINGLE, DMA_DONE} dma_state_e;
  typedef enum logic [1:0] {AB_OFF, AB_WAIT_IDLE, AB_WAIT_START, AB_MEASURE} ab_state_e;

endpackage
